// file: core/ddr_dual_pkg.sv
package ddr_dual_pkg;
   localparam logic [7:0] OP_READ = 8'hBD;
   localparam logic [7:0] OP_READ_4B = 8'hBE;
   localparam logic [5:0] OPC_CLKS = 6'h08;
   localparam logic [5:0] MODE_CLKS = 6'h02;
   localparam logic [4:0] PRE_CLKS = 5'h04;
   localparam logic [3:0] NIB_3B = 4'h6;
   localparam logic [3:0] NIB_4B = 4'h8;
   localparam int MEM_AW = 10;
   localparam int CORE_MHZ = 25;
   localparam int LINK_MAX_MHZ = 80;
   // Four core cycles per link clock keep the link well under its ceiling.
   localparam int LINK_DIV = 4;
   localparam int LINK_MHZ = CORE_MHZ / LINK_DIV;
   localparam logic [2:0] GAP_CYC = 3'h4;
   localparam logic [7:0] DLP_RESET = 8'h34;
   // Dummy clocks per latency code; each entry stays at or above PRE_CLKS.
   localparam logic [4:0] LAT_STD [4] = '{5'h05, 5'h06, 5'h07, 5'h08};
   localparam logic [4:0] LAT_ENH [4] = '{5'h04, 5'h05, 5'h06, 5'h07};
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam logic [7:0] REG_DLP = 8'h10;
   localparam int CTRL_START = 0;
   localparam int CTRL_OP4B = 1;
   localparam int CTRL_WIDE = 2;
   localparam int CTRL_ENH = 3;
   localparam int CTRL_DLP = 4;
   localparam int CTRL_LC = 5;
   localparam int CTRL_MODE = 8;
   localparam int CTRL_LEN = 16;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_PRE_ERR = 2;
   localparam int ST_CONT = 3;

   function automatic logic [4:0] dummy_clocks(input logic enh, input logic [1:0] lc);
      return enh ? LAT_ENH[lc] : LAT_STD[lc];
   endfunction : dummy_clocks

   function automatic logic mode_complement(input logic [7:0] m);
      return m[7:4] == ~m[3:0];
   endfunction : mode_complement
endpackage : ddr_dual_pkg

// file: core/spi_ddr_if.sv
`timescale 1ns/1ns
interface spi_ddr_if;
   logic sck;
   logic cs_n;
   logic [1:0] h_io_o;
   logic [1:0] h_io_oe_n;
   logic [1:0] d_io_o;
   logic [1:0] d_io_oe_n;
   logic [1:0] io;

   // Released lines are pulled high.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         io[i] = !h_io_oe_n[i] ? h_io_o[i] : (!d_io_oe_n[i] ? d_io_o[i] : 1'b1);
      end
   end

   modport host_mp(output sck, output cs_n, output h_io_o, output h_io_oe_n, input io);
   modport dev_mp(input sck, input cs_n, input io, output d_io_o, output d_io_oe_n);
endinterface : spi_ddr_if

// file: core/ddr_dual_flash_dev.sv
`timescale 1ns/1ns
module ddr_dual_flash_dev (
   spi_ddr_if.dev_mp LINK,
   input wire logic I_CORE_CLK,
   input wire logic I_RESETN,
   input wire logic I_WIDE_ADDRESS_SELECT,
   input wire logic I_ENHANCED_LATENCY_TABLE,
   input wire logic I_DLP_ENABLE,
   input wire logic [1:0] I_LATENCY_CODE,
   input wire logic [7:0] I_DLP_PATTERN,
   input wire logic I_LOAD_WE,
   input wire logic [ddr_dual_pkg::MEM_AW-1:0] I_LOAD_ADDR,
   input wire logic [7:0] I_LOAD_DATA,
   output logic O_CONTINUOUS
);
   typedef enum logic [2:0] {S_OPC, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_IGNORE} dev_state_e;

   logic [7:0] mem [2**ddr_dual_pkg::MEM_AW];
   logic [12:0] cfg_s1_r, cfg_s2_r;
   logic rst_s1_r, rst_s2_r;
   logic wide, enh, dlp_en;
   logic [1:0] lc;
   logic [7:0] pat;
   logic [1:0] rise_r;
   logic [3:0] nib;
   dev_state_e state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [3:0] ntot_r, ntot_nxt;
   logic [4:0] dcnt_r, dcnt_nxt;
   logic [6:0] op_r;
   logic [7:0] op_full;
   logic [31:0] ad_r, ad_nxt;
   logic [3:0] md_r;
   logic addr_take, addr_last, mode_last;
   logic [ddr_dual_pkg::MEM_AW-1:0] addr_r;
   logic half_r;
   logic [3:0] out_r;
   logic drive_r;
   logic [1:0] lo_r;
   logic drv_lo_r;
   logic cont_r, cont4_r;
   logic cont_c1_r, cont_c2_r;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_LOAD_WE) begin
         mem[I_LOAD_ADDR] <= I_LOAD_DATA;
      end
   end

   // Static settings cross into the link domain; the opcode clocks give them time to settle.
   always_ff @(negedge LINK.sck) begin
      cfg_s1_r <= {I_WIDE_ADDRESS_SELECT, I_ENHANCED_LATENCY_TABLE, I_DLP_ENABLE,
                   I_LATENCY_CODE, I_DLP_PATTERN};
      cfg_s2_r <= cfg_s1_r;
      rst_s1_r <= I_RESETN;
      rst_s2_r <= rst_s1_r;
   end
   assign wide = cfg_s2_r[12];
   assign enh = cfg_s2_r[11];
   assign dlp_en = cfg_s2_r[10];
   assign lc = cfg_s2_r[9:8];
   assign pat = cfg_s2_r[7:0];

   always_ff @(posedge LINK.sck) begin
      rise_r <= LINK.io;
   end
   assign nib = {rise_r, LINK.io};
   assign op_full = {op_r, rise_r[0]};
   assign addr_take = (state_r == S_ADDR) || (state_r == S_OPC && cnt_r == 4'h0 && cont_r);
   // Only the registered count is used here, so the next-state logic has no loop through it.
   assign addr_last = (state_r == S_ADDR) && (cnt_r == 4'(ntot_r - 4'h1));
   assign mode_last = (state_r == S_MODE) && (cnt_r == 4'h1);
   assign ad_nxt = {ad_r[27:0], nib};

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = 4'(cnt_r + 4'h1);
      ntot_nxt = ntot_r;
      dcnt_nxt = dcnt_r;
      case (state_r)
         S_OPC: begin
            if (cnt_r == 4'h0 && cont_r) begin
               state_nxt = S_ADDR;
               ntot_nxt = cont4_r ? ddr_dual_pkg::NIB_4B : ddr_dual_pkg::NIB_3B;
            end else if (cnt_r == 4'(ddr_dual_pkg::OPC_CLKS - 6'h01)) begin
               cnt_nxt = 4'h0;
               if (op_full == ddr_dual_pkg::OP_READ) begin
                  state_nxt = S_ADDR;
                  ntot_nxt = wide ? ddr_dual_pkg::NIB_4B : ddr_dual_pkg::NIB_3B;
               end else if (op_full == ddr_dual_pkg::OP_READ_4B) begin
                  state_nxt = S_ADDR;
                  ntot_nxt = ddr_dual_pkg::NIB_4B;
               end else begin
                  state_nxt = S_IGNORE;
               end
            end
         end
         S_ADDR: begin
            if (addr_last) begin
               cnt_nxt = 4'h0;
               if (enh) begin
                  state_nxt = S_MODE;
               end else begin
                  state_nxt = S_DUMMY;
                  dcnt_nxt = ddr_dual_pkg::dummy_clocks(enh, lc);
               end
            end
         end
         S_MODE: begin
            if (mode_last) begin
               state_nxt = S_DUMMY;
               dcnt_nxt = ddr_dual_pkg::dummy_clocks(enh, lc);
            end
         end
         S_DUMMY: begin
            if (dcnt_r == 5'h01) begin
               state_nxt = S_DATA;
            end else begin
               dcnt_nxt = 5'(dcnt_r - 5'h01);
            end
         end
         S_DATA: state_nxt = S_DATA;
         S_IGNORE: state_nxt = S_IGNORE;
         default: state_nxt = S_IGNORE;
      endcase
      if (addr_take && state_r == S_OPC && !(cnt_r == 4'h0 && cont_r)) begin
         ntot_nxt = ntot_r;
      end
   end

   // Frame state ends with the frame: raising select clears it at once.
   always_ff @(negedge LINK.sck or posedge LINK.cs_n) begin
      if (LINK.cs_n) begin
         state_r <= S_OPC;
         cnt_r <= 4'h0;
         ntot_r <= 4'h0;
         dcnt_r <= 5'h00;
         op_r <= 7'h00;
         ad_r <= 32'h0000_0000;
         md_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         ntot_r <= ntot_nxt;
         dcnt_r <= dcnt_nxt;
         if (state_r == S_OPC) begin
            op_r <= op_full[6:0];
         end
         if (addr_take) begin
            ad_r <= ad_nxt;
         end
         if (state_r == S_MODE) begin
            md_r <= nib;
         end
      end
   end

   always_ff @(negedge LINK.sck or posedge LINK.cs_n) begin
      if (LINK.cs_n) begin
         out_r <= 4'h0;
         drive_r <= 1'b0;
         half_r <= 1'b0;
         addr_r <= '0;
      end else begin
         out_r <= 4'h0;
         drive_r <= 1'b0;
         if (addr_last) begin
            addr_r <= ad_nxt[ddr_dual_pkg::MEM_AW-1:0];
         end
         if (state_nxt == S_DUMMY && dlp_en && dcnt_nxt <= ddr_dual_pkg::PRE_CLKS) begin
            drive_r <= 1'b1;
            out_r <= {{2{pat[3'(2 * dcnt_nxt - 5'h01)]}},
                      {2{pat[3'(2 * dcnt_nxt - 5'h02)]}}};
         end else if (state_nxt == S_DATA) begin
            drive_r <= 1'b1;
            half_r <= !half_r;
            if (!half_r) begin
               out_r <= mem[addr_r][7:4];
            end else begin
               out_r <= mem[addr_r][3:0];
               if (addr_r == '1) begin
                  addr_r <= '0;
               end else begin
                  addr_r <= addr_r + 1'b1;
               end
            end
         end
      end
   end

   // The upper pair shows while the clock is high, the lower pair after the falling edge.
   always_ff @(posedge LINK.sck or posedge LINK.cs_n) begin
      if (LINK.cs_n) begin
         lo_r <= 2'h0;
         drv_lo_r <= 1'b0;
      end else begin
         lo_r <= out_r[1:0];
         drv_lo_r <= drive_r;
      end
   end
   assign LINK.d_io_o = LINK.sck ? out_r[3:2] : lo_r;
   // There is no pause input, so nothing can stall the output mid-read.
   assign LINK.d_io_oe_n = {2{!(LINK.sck ? drive_r : drv_lo_r)}};

   // Every frame starts by dropping continuous mode; only a complementary mode byte re-arms it.
   always_ff @(negedge LINK.sck) begin
      if (!rst_s2_r) begin
         cont_r <= 1'b0;
         cont4_r <= 1'b0;
      end else if (!LINK.cs_n && state_r == S_OPC && cnt_r == 4'h0) begin
         cont_r <= 1'b0;
      end else if (!LINK.cs_n && mode_last) begin
         cont_r <= ddr_dual_pkg::mode_complement({md_r, nib});
         cont4_r <= (ntot_r == ddr_dual_pkg::NIB_4B);
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         cont_c1_r <= 1'b0;
         cont_c2_r <= 1'b0;
      end else begin
         cont_c1_r <= cont_r;
         cont_c2_r <= cont_c1_r;
      end
   end
   assign O_CONTINUOUS = cont_c2_r;
endmodule : ddr_dual_flash_dev

// file: core/ddr_dual_flash_host.sv
`timescale 1ns/1ns
module ddr_dual_flash_host (
   spi_ddr_if.host_mp LINK,
   input wire logic I_CORE_CLK,
   input wire logic I_RESETN,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR
);
   typedef enum logic [1:0] {H_IDLE, H_FRAME, H_GAP} host_state_e;

   host_state_e state_r;
   logic [1:0] ph_r;
   logic [5:0] cnt_r, op_end_r, md_end_r, ds_r, fe_r;
   logic [2:0] gap_r;
   logic [39:0] tx_r;
   logic [7:0] opc_r, dlp_r, mode_r;
   logic [31:0] addr_r, rx_r, rdata_r;
   logic op4b_r, wide_r, enh_r, dlpen_r, cont_r, done_r, pre_err_r, sck_r, cs_n_r;
   logic [1:0] lc_r;
   logic [2:0] len_r;
   logic [1:0] io_s1_r, io_s2_r, h_o_r, h_oe_n_r;
   logic wr, start, samp;
   logic [5:0] c, rem;
   logic [4:0] lat;
   logic exp_bit;

   assign wr = I_PSEL && I_PENABLE && I_PWRITE;
   assign start = wr && I_PADDR == ddr_dual_pkg::REG_CTRL && I_PWDATA[ddr_dual_pkg::CTRL_START]
                  && state_r == H_IDLE;
   assign lat = ddr_dual_pkg::dummy_clocks(I_PWDATA[ddr_dual_pkg::CTRL_ENH],
                                           I_PWDATA[ddr_dual_pkg::CTRL_LC+:2]);
   assign c = 6'(cnt_r - 6'h01);
   assign rem = 6'(ds_r - c);
   assign samp = state_r == H_FRAME && (ph_r == 2'h3 || ph_r == 2'h1);
   // The sample at phase 3 holds the rise pair of a clock, the one at phase 1 its fall pair.
   assign exp_bit = dlp_r[3'(2 * rem - {5'h00, ph_r == 2'h1 ? 1'b1 : 1'b0} - 6'h01)];

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         io_s1_r <= 2'h3;
         io_s2_r <= 2'h3;
      end else begin
         io_s1_r <= LINK.io;
         io_s2_r <= io_s1_r;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         {op4b_r, wide_r, enh_r, dlpen_r} <= 4'h0;
         lc_r <= 2'h0;
         len_r <= 3'h0;
         mode_r <= 8'h00;
         addr_r <= 32'h0000_0000;
         dlp_r <= ddr_dual_pkg::DLP_RESET;
      end else if (wr && state_r == H_IDLE) begin
         if (I_PADDR == ddr_dual_pkg::REG_CTRL) begin
            op4b_r <= I_PWDATA[ddr_dual_pkg::CTRL_OP4B];
            wide_r <= I_PWDATA[ddr_dual_pkg::CTRL_WIDE];
            enh_r <= I_PWDATA[ddr_dual_pkg::CTRL_ENH];
            dlpen_r <= I_PWDATA[ddr_dual_pkg::CTRL_DLP];
            lc_r <= I_PWDATA[ddr_dual_pkg::CTRL_LC+:2];
            mode_r <= I_PWDATA[ddr_dual_pkg::CTRL_MODE+:8];
            len_r <= I_PWDATA[ddr_dual_pkg::CTRL_LEN+:3];
         end
         if (I_PADDR == ddr_dual_pkg::REG_ADDR) begin
            addr_r <= I_PWDATA;
         end
         if (I_PADDR == ddr_dual_pkg::REG_DLP) begin
            dlp_r <= I_PWDATA[7:0];
         end
      end
   end

   // Frame timing: one link clock is four core cycles, sck high in phases 0 and 1.
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         state_r <= H_IDLE;
         ph_r <= 2'h0;
         cnt_r <= 6'h00;
         gap_r <= 3'h0;
         sck_r <= 1'b0;
         cs_n_r <= 1'b1;
         {op_end_r, md_end_r, ds_r, fe_r} <= 24'h00_0000;
         tx_r <= 40'h00_0000_0000;
         opc_r <= 8'h00;
         h_o_r <= 2'h0;
         h_oe_n_r <= 2'h3;
      end else begin
         case (state_r)
            H_IDLE: begin
               if (start) begin
                  state_r <= H_FRAME;
                  cs_n_r <= 1'b0;
                  ph_r <= 2'h2;
                  cnt_r <= 6'h00;
                  opc_r <= I_PWDATA[ddr_dual_pkg::CTRL_OP4B] ? ddr_dual_pkg::OP_READ_4B
                                                           : ddr_dual_pkg::OP_READ;
                  if (I_PWDATA[ddr_dual_pkg::CTRL_OP4B] || I_PWDATA[ddr_dual_pkg::CTRL_WIDE]) begin
                     tx_r <= {addr_r, I_PWDATA[ddr_dual_pkg::CTRL_MODE+:8]};
                  end else begin
                     tx_r <= {addr_r[23:0], I_PWDATA[ddr_dual_pkg::CTRL_MODE+:8], 8'h00};
                  end
                  op_end_r <= cont_r ? 6'h00 : ddr_dual_pkg::OPC_CLKS;
                  md_end_r <= md_end_r_calc(cont_r, I_PWDATA);
               end
            end
            H_FRAME: begin
               ph_r <= 2'(ph_r + 2'h1);
               if (ph_r == 2'h2 || ph_r == 2'h0) begin
                  if (cnt_r < op_end_r) begin
                     h_o_r <= {1'b0, opc_r[3'(6'h07 - cnt_r)]};
                     h_oe_n_r <= 2'h2;
                  end else if (cnt_r < md_end_r) begin
                     h_o_r <= tx_r[39:38];
                     tx_r <= {tx_r[37:0], 2'h0};
                     h_oe_n_r <= 2'h0;
                  end else begin
                     h_oe_n_r <= 2'h3;
                  end
               end
               if (ph_r == 2'h3) begin
                  sck_r <= cnt_r < fe_r;
               end
               if (ph_r == 2'h1) begin
                  sck_r <= 1'b0;
                  cnt_r <= 6'(cnt_r + 6'h01);
                  if (cnt_r == fe_r) begin
                     state_r <= H_GAP;
                     cs_n_r <= 1'b1;
                     gap_r <= ddr_dual_pkg::GAP_CYC;
                  end
               end
            end
            H_GAP: begin
               gap_r <= 3'(gap_r - 3'h1);
               if (gap_r == 3'h1) begin
                  state_r <= H_IDLE;
               end
            end
            default: state_r <= H_IDLE;
         endcase
         if (start) begin
            ds_r <= 6'(md_end_r_calc(cont_r, I_PWDATA) + {1'b0, lat});
            fe_r <= 6'(md_end_r_calc(cont_r, I_PWDATA) + {1'b0, lat}
                       + {2'h0, I_PWDATA[ddr_dual_pkg::CTRL_LEN+:3], 1'b0});
         end
      end
   end

   function automatic logic [5:0] md_end_r_calc(input logic cont, input logic [31:0] w);
      logic four;
      four = w[ddr_dual_pkg::CTRL_OP4B] || w[ddr_dual_pkg::CTRL_WIDE];
      return 6'((cont ? 6'h00 : ddr_dual_pkg::OPC_CLKS) + (four ? 6'h08 : 6'h06)
                + (w[ddr_dual_pkg::CTRL_ENH] ? ddr_dual_pkg::MODE_CLKS : 6'h00));
   endfunction : md_end_r_calc

   // Capture point is fixed; the preamble only confirms that it sits inside the eye.
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         rx_r <= 32'h0000_0000;
         rdata_r <= 32'h0000_0000;
         pre_err_r <= 1'b0;
         done_r <= 1'b0;
         cont_r <= 1'b0;
      end else begin
         if (wr && I_PADDR == ddr_dual_pkg::REG_STATUS && I_PWDATA[ddr_dual_pkg::ST_DONE]) begin
            done_r <= 1'b0;
         end
         if (start) begin
            rx_r <= 32'h0000_0000;
            pre_err_r <= 1'b0;
         end
         if (samp && c >= ds_r && c < fe_r) begin
            rx_r <= {rx_r[29:0], io_s2_r};
         end
         if (samp && dlpen_r && c < ds_r && rem <= 6'(ddr_dual_pkg::PRE_CLKS)
             && io_s2_r != {2{exp_bit}}) begin
            pre_err_r <= 1'b1;
         end
         if (state_r == H_FRAME && ph_r == 2'h1 && cnt_r == fe_r) begin
            done_r <= 1'b1;
            rdata_r <= (fe_r > ds_r) ? {rx_r[29:0], io_s2_r} : rx_r;
            cont_r <= enh_r && ddr_dual_pkg::mode_complement(mode_r);
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         O_PRDATA <= 32'h0000_0000;
         O_PSLVERR <= 1'b0;
      end else if (I_PSEL && !I_PENABLE) begin
         O_PSLVERR <= 1'b0;
         case (I_PADDR)
            ddr_dual_pkg::REG_CTRL: O_PRDATA <= {13'h0000, len_r, mode_r, 1'b0, lc_r,
                                                 dlpen_r, enh_r, wide_r, op4b_r, 1'b0};
            ddr_dual_pkg::REG_ADDR: O_PRDATA <= addr_r;
            ddr_dual_pkg::REG_STATUS: O_PRDATA <= {28'h000_0000, cont_r, pre_err_r, done_r,
                                                   state_r != H_IDLE};
            ddr_dual_pkg::REG_RDATA: O_PRDATA <= rdata_r;
            ddr_dual_pkg::REG_DLP: O_PRDATA <= {24'h00_0000, dlp_r};
            default: begin
               O_PRDATA <= 32'h0000_0000;
               O_PSLVERR <= 1'b1;
            end
         endcase
      end
   end
   assign O_PREADY = 1'b1;
   assign LINK.sck = sck_r;
   assign LINK.cs_n = cs_n_r;
   assign LINK.h_io_o = h_o_r;
   assign LINK.h_io_oe_n = h_oe_n_r;
endmodule : ddr_dual_flash_host

// file: verification/ddr_dual_properties.sv
`timescale 1ns/1ns
module ddr_dual_properties (
   input wire logic I_CORE_CLK,
   input wire logic I_RESETN,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [1:0] h_io_oe_n,
   input wire logic [1:0] d_io_oe_n,
   input wire logic [1:0] io
);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESETN);
   // A level that lasts two core cycles keeps the link far below its ceiling.
   a_link_rate: assert property ($changed(sck) |=> $stable(sck))
      else $error("link clock level too short");
   a_select_sck_low: assert property ($changed(cs_n) |-> !sck)
      else $error("select moved with clock high");
   a_clock_idle: assert property (cs_n |-> !sck)
      else $error("clock runs while deselected");
   a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*4])
      else $error("gap between frames too short");
   a_no_contention: assert property (((~h_io_oe_n) & (~d_io_oe_n)) == 2'h0)
      else $error("both ends drive a line");
   a_pair_enable: assert property (d_io_oe_n[1] == d_io_oe_n[0])
      else $error("device drives one line only");
   a_dev_hold: assert property (!d_io_oe_n[0] && !cs_n |=> !d_io_oe_n[0] || cs_n)
      else $error("device released lines inside frame");
   a_dev_idle: assert property (cs_n && $past(cs_n) |-> &d_io_oe_n)
      else $error("device drives while deselected");
   // Device pairs may only move with a clock edge, never between edges.
   a_dev_ddr_edges: assert property (!cs_n && &h_io_oe_n && $stable(h_io_oe_n)
      && $stable(sck) && $stable(d_io_oe_n) && !d_io_oe_n[0] |-> $stable(io))
      else $error("device data moved between edges");
endmodule : ddr_dual_properties

// file: verification/tb_ddr_dual_io_flash_read.sv
`timescale 1ns/1ns
module tb_ddr_dual_io_flash_read;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic pen = 1'h0;
   logic pwr = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, err, cont;
   logic wide = 1'h0;
   logic enh = 1'h0;
   logic data_learning_pattern = 1'h1;
   logic [1:0] lc = 2'h0;
   logic [7:0] pat = 8'h34;
   logic [7:0] ld = 8'h00;
   logic lwe = 1'h0;
   logic [9:0] la = 10'h000;
   int num_errors = 0;
   int compares = 0;
   spi_ddr_if link();
   ddr_dual_flash_host ddr_dual_flash_host_inst (.LINK(link.host_mp), .I_CORE_CLK(clk),
      .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
   ddr_dual_flash_dev ddr_dual_flash_dev_inst (.LINK(link.dev_mp), .I_CORE_CLK(clk),
      .I_RESETN(rst_n), .I_WIDE_ADDRESS_SELECT(wide), .I_ENHANCED_LATENCY_TABLE(enh),
      .I_DLP_ENABLE(data_learning_pattern), .I_LATENCY_CODE(lc), .I_DLP_PATTERN(pat), .I_LOAD_WE(lwe),
      .I_LOAD_ADDR(la), .I_LOAD_DATA(ld), .O_CONTINUOUS(cont));
   ddr_dual_properties ddr_dual_properties_inst (.I_CORE_CLK(clk), .I_RESETN(rst_n),
      .sck(link.sck), .cs_n(link.cs_n), .h_io_oe_n(link.h_io_oe_n),
      .d_io_oe_n(link.d_io_oe_n), .io(link.io));

   always #20 clk = ~clk;

   function automatic logic [7:0] exp_b(input logic [9:0] a);
      return {a[1:0], a[7:2]} ^ {6'h00, a[9:8]} ^ 8'h96;
   endfunction : exp_b

   task automatic give_verdict();
      $display("errors %0d, compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, pwr, paddr, pwdata} <= {1'h1, w, a, d};
      @(posedge clk);
      pen <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      {psel, pen} <= 2'h0;
   endtask : apb

   task automatic frame(input logic op4, input logic [7:0] mode, input logic [2:0] n,
         input logic [9:0] a, input logic cexp, input logic chk_on);
      logic [31:0] e;
      e = 32'h0;
      apb(1'h1, ddr_dual_pkg::REG_ADDR, {22'h0, a});
      apb(1'h1, ddr_dual_pkg::REG_CTRL, {13'h0, n, mode, 1'h0, lc, data_learning_pattern, enh, wide, op4, 1'h1});
      do apb(1'h0, ddr_dual_pkg::REG_STATUS, 32'h0); while (rd[ddr_dual_pkg::ST_BUSY] !== 1'h0);
      if (chk_on) begin
         chk({28'h0, rd[3:0]}, {28'h0, cexp, 3'h2}, "status");
         for (int i = 0; i < n; i++)
            e = {e[23:0], exp_b(a + 10'(i))};
         apb(1'h0, ddr_dual_pkg::REG_RDATA, 32'h0);
         chk(rd, e, "read data");
         repeat (4) @(posedge clk);
         chk({31'h0, cont}, {31'h0, cexp}, "continuous flag");
      end
   endtask : frame

   // The device syncs its settings on link edges only, so a spare frame lets them land.
   task automatic cfg(input logic w, input logic en, input logic d, input logic [1:0] l,
         input logic [7:0] p);
      {wide, enh, data_learning_pattern, lc, pat} <= {w, en, d, l, p};
      apb(1'h1, ddr_dual_pkg::REG_DLP, {24'h0, p});
      frame(1'h0, 8'h00, 3'h0, 10'h000, 1'h0, 1'h0);
   endtask : cfg

   initial begin
      repeat (30000) @(posedge clk);
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      give_verdict();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      for (int i = 0; i < 1024; i++) begin
         @(posedge clk);
         {lwe, la, ld} <= {1'h1, 10'(i), exp_b(10'(i))};
      end
      @(posedge clk);
      lwe <= 1'h0;
      apb(1'h0, ddr_dual_pkg::REG_DLP, 32'h0);
      chk(rd, 32'h34, "pattern reset");
      apb(1'h0, 8'h40, 32'h0);
      chk({rd[30:0], err}, 32'h1, "unmapped");
      apb(1'h1, ddr_dual_pkg::REG_CTRL, 32'h0002_A55A);
      apb(1'h0, ddr_dual_pkg::REG_CTRL, 32'h0);
      chk(rd, 32'h0002_A55A, "control readback");
      cfg(1'h0, 1'h0, 1'h1, 2'h0, 8'h34);
      frame(1'h0, 8'h00, 3'h4, 10'h3FE, 1'h0, 1'h1);
      apb(1'h1, ddr_dual_pkg::REG_STATUS, 32'h0000_0002);
      apb(1'h0, ddr_dual_pkg::REG_STATUS, 32'h0);
      chk({31'h0, rd[ddr_dual_pkg::ST_DONE]}, 32'h0, "done cleared");
      frame(1'h1, 8'h00, 3'h3, 10'h123, 1'h0, 1'h1);
      cfg(1'h0, 1'h0, 1'h0, 2'h3, 8'h34);
      for (int l = 0; l < 4; l++) begin
         cfg(1'h1, 1'h0, 1'h0, 2'(l), 8'h34);
         frame(1'h0, 8'h00, 3'h2, 10'h200 + 10'(l), 1'h0, 1'h1);
      end
      cfg(1'h0, 1'h1, 1'h1, 2'h1, 8'hC3);
      frame(1'h0, 8'h5A, 3'h2, 10'h050, 1'h1, 1'h1);
      frame(1'h0, 8'hA5, 3'h3, 10'h3FF, 1'h1, 1'h1);
      frame(1'h0, 8'h00, 3'h2, 10'h080, 1'h0, 1'h1);
      frame(1'h1, 8'h0F, 3'h1, 10'h011, 1'h1, 1'h1);
      // A continuous frame keeps the address width of the frame that armed it.
      frame(1'h1, 8'h12, 3'h4, 10'h1FE, 1'h0, 1'h1);
      give_verdict();
   end
endmodule : tb_ddr_dual_io_flash_read
